// ==== design/ctb_ctr_timer.sv ====
/*
 Two counter/timers and two baud timers behind an APB slave.
 Assumes port pins and the channel A 1x clock are asynchronous, and the
 receive FIFO load pulse and auxiliary control settings come from sys_clk logic.
*/
`timescale 1ns/1ns
`include "ctb_cfg.svh"

// Notes on behaviour
// - Mode 00 makes a counter that ticks down, mode 01 a square-wave timer, 10 is reserved.
// - Mode 11 gives pulses at twice the square-wave rate, each one counter tick wide.
// - Clock codes 0000 and 0001 take the timer's own port pin, direct or divided by 16.
// - Code 1000 takes the channel A 1x transmit clock and 1100 each receive FIFO load.
// - Writing a source register takes control of that timer from the auxiliary settings.
// - The upper value register reads count bits 15 to 8, the lower one bits 7 to 0.
// - Each baud timer divides its chosen clock by its 16-bit divisor into a 16x tick.
// - A baud timer's user runs in 16x mode and divides that tick by 16 again.
// - Baud timer 1 run bit 7 low resets and holds it, high lets it run.
// - Baud timer 1 select bits 6:4 pick clock /1,/2,/6,/32,/64,/128 or port pin 4A.
// - Baud timer 0 uses run bit 3 and select bits 2:0, with /16 and port pin 3A instead.
// - Each baud divisor is built from an upper byte and a lower byte register.
module ctb_ctr_timer (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [9:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Asynchronous clock pins
    input  wire logic                 port_pin_two_a,
    input  wire logic                 port_pin_seven_a,
    input  wire logic                 port_pin_four_a,
    input  wire logic                 port_pin_three_a,
    input  wire logic                 chan_a_tx_single_rate_clock,
    // Same-domain sources
    input  wire logic                 rx_fifo_load,
    input  wire ctb_pkg::ctb_ct_cfg_t aux_t0_cfg,
    input  wire ctb_pkg::ctb_ct_cfg_t aux_t1_cfg,
    // Timer outputs
    output logic [1:0]                ct_wave,
    output logic [1:0]                baud_x16_tick,
    output logic [1:0]                baud_bit_tick
);
    import ctb_pkg::*;

    // Pin synchronisers: stage 1 feeds stage 2 only
    logic [4:0]  sync1_r;
    logic [4:0]  sync2_r;
    logic [4:0]  sync3_r;
    logic [6:0]  pre_r;
    logic [2:0]  div6_r;
    logic [7:0]  t0_src_r;
    logic [7:0]  t1_src_r;
    logic [7:0]  br_src_r;
    logic [1:0]  ovr_r;
    logic [1:0]  ct_run_r;
    logic [1:0]  ct_start_r;
    logic [15:0] t0_pre_r;
    logic [15:0] t1_pre_r;
    logic [15:0] br0_div_r;
    logic [15:0] br1_div_r;
    logic [31:0] prdata_r;

    wire [4:0] pin_raw = {chan_a_tx_single_rate_clock, port_pin_three_a,
                          port_pin_four_a, port_pin_seven_a, port_pin_two_a};
    wire [4:0] rise    = sync2_r & ~sync3_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            sync3_r <= 5'h00;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Shared prescaler for all system-clock taps
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_r  <= 7'h00;
            div6_r <= 3'h0;
        end else begin
            pre_r  <= pre_r + 7'h01;
            div6_r <= (div6_r == `CTB_DIV6_LAST) ? 3'h0 : div6_r + 3'h1;
        end
    end

    ctb_taps_t taps;
    assign taps.div1   = 1'b1;
    assign taps.div2   = ctb_low_ones(pre_r, 7'h01);
    assign taps.div6   = div6_r == `CTB_DIV6_LAST;
    assign taps.div16  = ctb_low_ones(pre_r, 7'h0f);
    assign taps.div32  = ctb_low_ones(pre_r, 7'h1f);
    assign taps.div64  = ctb_low_ones(pre_r, 7'h3f);
    assign taps.div128 = ctb_low_ones(pre_r, 7'h7f);

    // APB decode; zero wait states
    wire [7:0] idx     = paddr[9:2];
    wire       aligned = paddr[1:0] == 2'b00;
    wire       setup   = psel & ~penable;
    wire       acc     = psel & penable;
    wire hit_t0_hi  = aligned & (idx == `CTB_IX_T0_HI);
    wire hit_t0_lo  = aligned & (idx == `CTB_IX_T0_LO);
    wire hit_t1_hi  = aligned & (idx == `CTB_IX_T1_HI);
    wire hit_t1_lo  = aligned & (idx == `CTB_IX_T1_LO);
    wire hit_t0_src = aligned & (idx == `CTB_IX_T0_SRC);
    wire hit_t1_src = aligned & (idx == `CTB_IX_T1_SRC);
    wire hit_br_src = aligned & (idx == `CTB_IX_BR_SRC);
    wire hit_br0_lo = aligned & (idx == `CTB_IX_BR0_LO);
    wire hit_br0_hi = aligned & (idx == `CTB_IX_BR0_HI);
    wire hit_br1_lo = aligned & (idx == `CTB_IX_BR1_LO);
    wire hit_br1_hi = aligned & (idx == `CTB_IX_BR1_HI);
    wire hit_run    = aligned & (idx == `CTB_IX_CT_RUN);
    wire hit_any    = hit_t0_hi | hit_t0_lo | hit_t1_hi | hit_t1_lo | hit_t0_src
                    | hit_t1_src | hit_br_src | hit_br0_lo | hit_br0_hi
                    | hit_br1_lo | hit_br1_hi | hit_run;
    wire       wr      = acc & pwrite & hit_any;
    wire [7:0] wb      = pwdata[7:0];

    wire [15:0] t0_cnt;
    wire [15:0] t1_cnt;

    // Value registers read the live count; preset bytes are write-only there
    wire [7:0] rd_byte = hit_t0_hi  ? t0_cnt[15:8] :
                         hit_t0_lo  ? t0_cnt[7:0]  :
                         hit_t1_hi  ? t1_cnt[15:8] :
                         hit_t1_lo  ? t1_cnt[7:0]  :
                         hit_t0_src ? {2'b00, t0_src_r[5:0]} :
                         hit_t1_src ? {2'b00, t1_src_r[5:0]} :
                         hit_br_src ? br_src_r :
                         hit_br0_lo ? br0_div_r[7:0]  :
                         hit_br0_hi ? br0_div_r[15:8] :
                         hit_br1_lo ? br1_div_r[7:0]  :
                         hit_br1_hi ? br1_div_r[15:8] :
                         hit_run    ? {6'h00, ct_run_r} : 8'h00;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t0_src_r <= `CTB_SRC_RST;
            t1_src_r <= `CTB_SRC_RST;
            br_src_r <= `CTB_BR_RST;
            ovr_r    <= 2'b00;
        end else begin
            t0_src_r <= (wr && hit_t0_src) ? wb : t0_src_r;
            t1_src_r <= (wr && hit_t1_src) ? wb : t1_src_r;
            br_src_r <= (wr && hit_br_src) ? wb : br_src_r;
            ovr_r    <= ovr_r | {wr & hit_t1_src, wr & hit_t0_src};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t0_pre_r  <= 16'h0000;
            t1_pre_r  <= 16'h0000;
            br0_div_r <= 16'h0000;
            br1_div_r <= 16'h0000;
        end else begin
            t0_pre_r[15:8]  <= (wr && hit_t0_hi)  ? wb : t0_pre_r[15:8];
            t0_pre_r[7:0]   <= (wr && hit_t0_lo)  ? wb : t0_pre_r[7:0];
            t1_pre_r[15:8]  <= (wr && hit_t1_hi)  ? wb : t1_pre_r[15:8];
            t1_pre_r[7:0]   <= (wr && hit_t1_lo)  ? wb : t1_pre_r[7:0];
            br0_div_r[15:8] <= (wr && hit_br0_hi) ? wb : br0_div_r[15:8];
            br0_div_r[7:0]  <= (wr && hit_br0_lo) ? wb : br0_div_r[7:0];
            br1_div_r[15:8] <= (wr && hit_br1_hi) ? wb : br1_div_r[15:8];
            br1_div_r[7:0]  <= (wr && hit_br1_lo) ? wb : br1_div_r[7:0];
        end
    end

    // Any write to the run register restarts the enabled timers from preset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ct_run_r   <= 2'b00;
            ct_start_r <= 2'b00;
        end else begin
            ct_run_r   <= (wr && hit_run) ? wb[1:0] : ct_run_r;
            ct_start_r <= (wr && hit_run) ? wb[1:0] : 2'b00;
        end
    end

    ctb_ct_cfg_t t0_reg_cfg;
    ctb_ct_cfg_t t1_reg_cfg;
    assign t0_reg_cfg = {t0_src_r[`CTB_SRC_MODE], t0_src_r[`CTB_SRC_CLK]};
    assign t1_reg_cfg = {t1_src_r[`CTB_SRC_MODE], t1_src_r[`CTB_SRC_CLK]};
    ctb_ct_cfg_t t0_cfg;
    ctb_ct_cfg_t t1_cfg;
    assign t0_cfg = ovr_r[0] ? t0_reg_cfg : aux_t0_cfg;
    assign t1_cfg = ovr_r[1] ? t1_reg_cfg : aux_t1_cfg;

    ctb_ct_chan u_ct0 (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .cfg       (t0_cfg),
        .run       (ct_run_r[0]),
        .start     (ct_start_r[0]),
        .preset    (t0_pre_r),
        .taps      (taps),
        .pin_tick  (rise[0]),
        .tx1x_tick (rise[4]),
        .rx_load   (rx_fifo_load),
        .count     (t0_cnt),
        .wave      (ct_wave[0])
    );

    ctb_ct_chan u_ct1 (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .cfg       (t1_cfg),
        .run       (ct_run_r[1]),
        .start     (ct_start_r[1]),
        .preset    (t1_pre_r),
        .taps      (taps),
        .pin_tick  (rise[1]),
        .tx1x_tick (rise[4]),
        .rx_load   (rx_fifo_load),
        .count     (t1_cnt),
        .wave      (ct_wave[1])
    );

    ctb_baud_tmr u_br0 (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .run      (br_src_r[`CTB_BR0_RUN]),
        .sel      (br_src_r[`CTB_BR0_SEL]),
        .divisor  (br0_div_r),
        .taps     (taps),
        .alt_tick (taps.div16),
        .pin_tick (rise[3]),
        .x16_tick (baud_x16_tick[0]),
        .bit_tick (baud_bit_tick[0])
    );

    ctb_baud_tmr u_br1 (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .run      (br_src_r[`CTB_BR1_RUN]),
        .sel      (br_src_r[`CTB_BR1_SEL]),
        .divisor  (br1_div_r),
        .taps     (taps),
        .alt_tick (taps.div6),
        .pin_tick (rise[2]),
        .x16_tick (baud_x16_tick[1]),
        .bit_tick (baud_bit_tick[1])
    );

    override_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr && hit_t0_src) |=> (ovr_r[0] && t0_cfg == t0_reg_cfg))
        else $error("source write did not take over from aux settings");
    count_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (setup && hit_t0_hi) |=> prdata == {24'h00_0000, $past(t0_cnt[15:8])})
        else $error("upper value read wrong count byte");
    divisor_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr && hit_br0_lo) |=> br0_div_r[7:0] == $past(pwdata[7:0]))
        else $error("divisor low byte not stored");
    div16_tap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        taps.div16 |=> !taps.div16 [*8] ##8 taps.div16)
        else $error("divide by 16 tap period wrong");
    override_t1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr && hit_t1_src) |=> (ovr_r[1] && t1_cfg == t1_reg_cfg))
        else $error("timer 1 source write did not take over");
    count_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (setup && hit_t1_lo) |=> prdata == {24'h00_0000, $past(t1_cnt[7:0])})
        else $error("lower value read wrong count byte");
    div6_tap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        taps.div6 |=> !taps.div6 [*5] ##1 taps.div6)
        else $error("divide by 6 tap period wrong");
    // Stopping a baud timer must silence its tick from the next edge on
    baud0_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !br_src_r[`CTB_BR0_RUN] |=> !baud_x16_tick[0])
        else $error("stopped baud timer 0 still ticked");
    baud1_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !br_src_r[`CTB_BR1_RUN] |=> !baud_x16_tick[1])
        else $error("stopped baud timer 1 still ticked");
    override_c: cover property (@(posedge sys_clk) wr && hit_t1_src);
    read_count_c: cover property (@(posedge sys_clk) acc && !pwrite && hit_t1_lo);
    pin_edge_c: cover property (@(posedge sys_clk) rise[0] || rise[2]);
endmodule : ctb_ctr_timer

// ==== inc/ctb_cfg.svh ====
/*
 Register indexes, field positions, codes and reset values of the
 counter/timer and baud-timer block. Byte address is four times the index.
*/
`ifndef CTB_CFG_SVH
`define CTB_CFG_SVH
`define CTB_IX_T0_HI   8'h16
`define CTB_IX_T0_LO   8'h17
`define CTB_IX_T1_HI   8'h1e
`define CTB_IX_T1_LO   8'h1f
`define CTB_IX_T0_SRC  8'h24
`define CTB_IX_T1_SRC  8'h2c
`define CTB_IX_BR_SRC  8'h33
`define CTB_IX_BR0_LO  8'h26
`define CTB_IX_BR0_HI  8'h27
`define CTB_IX_BR1_LO  8'h36
`define CTB_IX_BR1_HI  8'h37
`define CTB_IX_CT_RUN  8'h38
`define CTB_SRC_MODE   5:4
`define CTB_SRC_CLK    3:0
`define CTB_SRC_W      6
`define CTB_BR1_RUN    7
`define CTB_BR1_SEL    6:4
`define CTB_BR0_RUN    3
`define CTB_BR0_SEL    2:0
`define CTB_MODE_CNT   2'b00
`define CTB_MODE_TMR   2'b01
`define CTB_MODE_RSV   2'b10
`define CTB_MODE_PLS   2'b11
`define CTB_CS_PIN     4'h0
`define CTB_CS_PIN16   4'h1
`define CTB_CS_SYS     4'h2
`define CTB_CS_SYS2    4'h3
`define CTB_CS_SYS16   4'h4
`define CTB_CS_SYS32   4'h5
`define CTB_CS_SYS64   4'h6
`define CTB_CS_SYS128  4'h7
`define CTB_CS_TX1X    4'h8
`define CTB_CS_RXLD    4'hc
`define CTB_BS_SYS     3'h0
`define CTB_BS_SYS2    3'h1
`define CTB_BS_ALT     3'h2
`define CTB_BS_SYS32   3'h3
`define CTB_BS_SYS64   3'h4
`define CTB_BS_SYS128  3'h5
`define CTB_BS_PIN     3'h6
`define CTB_SRC_RST    8'h00
`define CTB_BR_RST     8'h00
`define CTB_DIV6_LAST  3'h5
`endif

// ==== inc/ctb_pkg.sv ====
/*
 Types shared by the counter/timer block.
 Assumes ctb_cfg.svh is on the include path.
*/
package ctb_pkg;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] clk_sel;
    } ctb_ct_cfg_t;

    typedef struct packed {
        logic div1;
        logic div2;
        logic div6;
        logic div16;
        logic div32;
        logic div64;
        logic div128;
    } ctb_taps_t;

    function automatic logic ctb_low_ones(input logic [6:0] v, input logic [6:0] m);
        return (v & m) == m;
    endfunction : ctb_low_ones
endpackage : ctb_pkg

// ==== design/ctb_ct_chan.sv ====
/*
 One 16-bit counter/timer: clock selection, mode and count.
 Assumes pin_tick is a synchronised one-cycle edge pulse and taps come
 from a shared prescaler on sys_clk.
*/
`timescale 1ns/1ns
`include "ctb_cfg.svh"
module ctb_ct_chan (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // Configuration
    input  wire ctb_pkg::ctb_ct_cfg_t cfg,
    input  wire logic               run,
    input  wire logic               start,
    input  wire logic [15:0]        preset,
    // Tick sources
    input  wire ctb_pkg::ctb_taps_t taps,
    input  wire logic               pin_tick,
    input  wire logic               tx1x_tick,
    input  wire logic               rx_load,
    // Results
    output logic [15:0]             count,
    output logic                    wave
);
    import ctb_pkg::*;

    logic [3:0]  pin16_r;
    logic [15:0] cnt_r;
    logic        out_r;

    wire pin16_tick = pin_tick & (pin16_r == 4'hf);
    wire [3:0] cs   = cfg.clk_sel;
    // Reserved codes yield no tick at all
    wire tick = (cs == `CTB_CS_PIN)    ? pin_tick     :
                (cs == `CTB_CS_PIN16)  ? pin16_tick   :
                (cs == `CTB_CS_SYS)    ? taps.div1    :
                (cs == `CTB_CS_SYS2)   ? taps.div2    :
                (cs == `CTB_CS_SYS16)  ? taps.div16   :
                (cs == `CTB_CS_SYS32)  ? taps.div32   :
                (cs == `CTB_CS_SYS64)  ? taps.div64   :
                (cs == `CTB_CS_SYS128) ? taps.div128  :
                (cs == `CTB_CS_TX1X)   ? tx1x_tick    :
                (cs == `CTB_CS_RXLD)   ? rx_load      : 1'b0;
    wire act      = run & tick & (cfg.mode != `CTB_MODE_RSV);
    wire is_cnt   = cfg.mode == `CTB_MODE_CNT;
    wire reload   = cnt_r <= 16'h1;
    wire [15:0] dec = cnt_r - 16'h1;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin16_r <= 4'h0;
        end else if (pin_tick) begin
            pin16_r <= pin16_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 16'h0;
            out_r <= 1'b0;
        end else if (start) begin
            cnt_r <= preset;
            out_r <= is_cnt;
        end else if (act && is_cnt) begin
            cnt_r <= dec;
            out_r <= (cnt_r == 16'h1) ? 1'b0 : out_r;
        end else if (act && cfg.mode == `CTB_MODE_TMR) begin
            cnt_r <= reload ? preset : dec;
            out_r <= reload ? ~out_r : out_r;
        end else if (act) begin
            // Pulse mode: full period per reload, high for one tick
            cnt_r <= reload ? preset : dec;
            out_r <= reload;
        end
    end

    assign count = cnt_r;
    assign wave  = out_r;

    rsvd_mode_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cfg.mode == `CTB_MODE_RSV && !start) |=> $stable(cnt_r))
        else $error("count moved in reserved mode");
    pin_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cs == `CTB_CS_PIN && is_cnt && run && pin_tick && !start) |=> cnt_r == $past(dec))
        else $error("pin edge did not decrement");
    sys_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cs == `CTB_CS_SYS && is_cnt && run && !start)[*2] |=> cnt_r == $past(cnt_r) - 16'h1)
        else $error("undivided clock did not count each cycle");
    rx_load_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cs == `CTB_CS_RXLD && !rx_load && !start) |=> $stable(cnt_r))
        else $error("count moved without fifo load");
    pulse_width_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cfg.mode == `CTB_MODE_PLS && out_r && act && !reload && !start) |=> !out_r)
        else $error("pulse longer than one tick");
    timer_toggle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cfg.mode == `CTB_MODE_TMR && act && reload && !start) |=> out_r != $past(out_r))
        else $error("square wave did not toggle at reload");
    pulse_seen_c: cover property (@(posedge sys_clk) cfg.mode == `CTB_MODE_PLS && out_r);
endmodule : ctb_ct_chan

// ==== design/ctb_baud_tmr.sv ====
/*
 One programmable baud timer: clock select, divisor, 16x and bit ticks.
 Assumes taps and pin_tick are single-cycle pulses on sys_clk.
*/
`timescale 1ns/1ns
`include "ctb_cfg.svh"
module ctb_baud_tmr (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // Control
    input  wire logic               run,
    input  wire logic [2:0]         sel,
    input  wire logic [15:0]        divisor,
    // Tick sources
    input  wire ctb_pkg::ctb_taps_t taps,
    input  wire logic               alt_tick,
    input  wire logic               pin_tick,
    // Results
    output logic                    x16_tick,
    output logic                    bit_tick
);
    import ctb_pkg::*;

    logic [15:0] cnt_r;
    logic [3:0]  sub_r;
    logic        x16_r;
    logic        bit_r;

    wire tick = (sel == `CTB_BS_SYS)    ? taps.div1   :
                (sel == `CTB_BS_SYS2)   ? taps.div2   :
                (sel == `CTB_BS_ALT)    ? alt_tick    :
                (sel == `CTB_BS_SYS32)  ? taps.div32  :
                (sel == `CTB_BS_SYS64)  ? taps.div64  :
                (sel == `CTB_BS_SYS128) ? taps.div128 :
                (sel == `CTB_BS_PIN)    ? pin_tick    : 1'b0;
    // Divisor 0 divides by 65536; a divisor lowered below the count wraps at once
    wire last = cnt_r >= divisor - 16'h1;
    wire wrap = run & tick & last;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 16'h0;
            sub_r <= 4'h0;
            x16_r <= 1'b0;
            bit_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= 16'h0;
            sub_r <= 4'h0;
            x16_r <= 1'b0;
            bit_r <= 1'b0;
        end else begin
            cnt_r <= !tick ? cnt_r : (last ? 16'h0 : cnt_r + 16'h1);
            sub_r <= wrap ? sub_r + 4'h1 : sub_r;
            x16_r <= wrap;
            bit_r <= wrap & (sub_r == 4'hf);
        end
    end

    assign x16_tick = x16_r;
    assign bit_tick = bit_r;

    divide_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (run && tick && last) |=> (x16_r && cnt_r == 16'h0))
        else $error("divisor end did not emit 16x tick");
    bit_sixteenth_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bit_r |-> (x16_r && sub_r == 4'h0))
        else $error("bit tick not on sixteenth 16x tick");
    stop_clears_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !run |=> (cnt_r == 16'h0 && !x16_r))
        else $error("stopped baud timer not held in reset");
    rsvd_sel_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (run && sel == 3'h7) |=> $stable(cnt_r))
        else $error("reserved select advanced timer");
    bit_tick_c: cover property (@(posedge sys_clk) bit_r);
endmodule : ctb_baud_tmr

// ==== sim/testbench.sv ====
/*
 Self-checking bench for the counter/timer and baud-timer block.
 Assumes ctb_cfg.svh and ctb_pkg are compiled first; APB master only.
*/
`timescale 1ns/1ns
`include "ctb_cfg.svh"
module testbench;
    import ctb_pkg::*;
    logic                 sys_clk, sys_rst, psel, penable, pwrite, rx_fifo_load;
    logic [9:0]           paddr;
    logic [31:0]          pwdata, prdata;
    logic                 pready, pslverr, pin2, pin7, pin4, pin3, txc;
    ctb_ct_cfg_t          aux0, aux1;
    logic [1:0]           wave, x16, bitt;
    logic [7:0]           rd;
    logic                 er;
    int                   num_errors = 0, num_checks = 0, cyc = 0;
    ctb_ctr_timer ctb_ctr_timer_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_pin_two_a(pin2), .port_pin_seven_a(pin7),
        .port_pin_four_a(pin4), .port_pin_three_a(pin3), .chan_a_tx_single_rate_clock(txc),
        .rx_fifo_load(rx_fifo_load), .aux_t0_cfg(aux0), .aux_t1_cfg(aux1), .ct_wave(wave),
        .baud_x16_tick(x16), .baud_bit_tick(bitt));
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Called just after a rising edge; holds the request until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 0; penable <= 0;
        // One idle edge so the next call never re-drives psel in this step
        @(posedge sys_clk);
    endtask : apb
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        apb(0, idx, 8'h00);
        chk(what, {8'h00, exp}, {8'h00, rd});
    endtask : rdchk
    task automatic loads(input int n);
        repeat (n) begin
            rx_fifo_load <= 1;
            @(posedge sys_clk);
            rx_fifo_load <= 0;
            repeat (2) @(posedge sys_clk);
        end
    endtask : loads
    // Cycles between two successive ticks of one baud output
    task automatic gap(input int ch, input logic b, input int exp);
        int n;
        n = 0;
        do @(posedge sys_clk); while ((b ? bitt[ch] : x16[ch]) !== 1'b1 && ++n < 300);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((b ? bitt[ch] : x16[ch]) !== 1'b1 && n < 300);
        chk("baud tick gap", 16'(exp), 16'(n));
    endtask : gap
    // Cycles in 48 with the timer wave (w=1) or the 16x tick (w=0) high
    task automatic highs(input int ch, input logic w, input int exp);
        int n;
        n = 0;
        repeat (48) begin
            @(posedge sys_clk);
            if ((w ? wave[ch] : x16[ch]) !== 1'b0) n++;
        end
        chk("high cycles", 16'(exp), 16'(n));
    endtask : highs
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        pin4 <= cyc[2];
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        rx_fifo_load = 0; pin2 = 0; pin7 = 0; pin3 = 0; txc = 0;
        aux0 = 6'h0c; aux1 = 6'h00;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 0;
        @(posedge sys_clk);
        apb(0, 8'h10, 8'h00);
        chk("unmapped error", 16'h1, {15'h0, er});
        // Count received loads under the side-band settings, then the register
        apb(1, `CTB_IX_T0_HI, 8'h01);
        apb(1, `CTB_IX_T0_LO, 8'h05);
        apb(1, `CTB_IX_CT_RUN, 8'h01);
        loads(6);
        rdchk("t0 high", `CTB_IX_T0_HI, 8'h00);
        rdchk("t0 low", `CTB_IX_T0_LO, 8'hff);
        apb(1, `CTB_IX_T0_SRC, 8'h09);
        loads(3);
        rdchk("t0 reserved clock", `CTB_IX_T0_LO, 8'hff);
        apb(1, `CTB_IX_T0_SRC, 8'h2c);
        loads(3);
        rdchk("t0 reserved mode", `CTB_IX_T0_LO, 8'hff);
        apb(1, `CTB_IX_T0_SRC, 8'h0c);
        loads(2);
        rdchk("t0 load count", `CTB_IX_T0_LO, 8'hfd);
        rdchk("t0 reread", `CTB_IX_T0_LO, 8'hfd);
        apb(1, `CTB_IX_CT_RUN, 8'h00);
        loads(2);
        rdchk("t0 stopped", `CTB_IX_T0_LO, 8'hfd);
        $display("Test counter sources done");
        // Pin edges pass a three-cycle synchroniser, so toggle slowly
        apb(1, `CTB_IX_T0_SRC, 8'h00);
        apb(1, `CTB_IX_CT_RUN, 8'h01);
        repeat (4) begin
            repeat (4) @(posedge sys_clk);
            pin2 <= 1;
            repeat (4) @(posedge sys_clk);
            pin2 <= 0;
        end
        repeat (6) @(posedge sys_clk);
        apb(1, `CTB_IX_CT_RUN, 8'h00);
        rdchk("t0 pin count", `CTB_IX_T0_LO, 8'h01);
        $display("Test pin clock done");
        // Timer 1 on the undivided clock: preset 3 gives a six-cycle square wave
        apb(1, `CTB_IX_T1_LO, 8'h03);
        apb(1, `CTB_IX_T1_SRC, 8'h12);
        apb(1, `CTB_IX_CT_RUN, 8'h02);
        highs(1, 1, 24);
        apb(1, `CTB_IX_T1_SRC, 8'h32);
        highs(1, 1, 16);
        $display("Test timer modes done");
        apb(1, `CTB_IX_BR0_LO, 8'h02);
        apb(1, `CTB_IX_BR0_HI, 8'h00);
        apb(1, `CTB_IX_BR_SRC, 8'h08);
        gap(0, 0, 2);
        gap(0, 1, 32);
        apb(1, `CTB_IX_BR0_LO, 8'h01);
        apb(1, `CTB_IX_BR_SRC, 8'h0a);
        gap(0, 0, 16);
        apb(1, `CTB_IX_BR1_LO, 8'h01);
        apb(1, `CTB_IX_BR1_HI, 8'h00);
        apb(1, `CTB_IX_BR_SRC, 8'ha0);
        gap(1, 0, 6);
        rdchk("baud source", `CTB_IX_BR_SRC, 8'ha0);
        apb(1, `CTB_IX_BR_SRC, 8'he0);
        gap(1, 0, 8);
        apb(1, `CTB_IX_BR_SRC, 8'h70);
        highs(1, 0, 0);
        apb(1, `CTB_IX_BR_SRC, 8'hf0);
        highs(1, 0, 0);
        $display("Test baud timers done");
        wrap_up();
    end
endmodule : testbench
